// ==== hdl/rca_consts.vh ====
// Constants for the eight-bit core: phases, register bus map, status bits,
// special file addresses, opcode fields and ALU operation codes.
// Assumes it is included by bare name from the ALU and core design files.
`ifndef RCA_CONSTS_VH
`define RCA_CONSTS_VH

// Instruction cycle timing, derived from the reference oscillator
`define RCA_OSC_REF_MHZ   20
`define RCA_ICYC_REF_NS   200
`define RCA_PHASES        (`RCA_ICYC_REF_NS * `RCA_OSC_REF_MHZ / 1000)
`define RCA_PH_ONE        2'h0
`define RCA_PH_TWO        2'h1
`define RCA_PH_THREE      2'h2
`define RCA_PH_FOUR       2'h3

// Register bus map and control fields
`define RCA_REG_CTRL      8'h00
`define RCA_REG_STATE     8'h04
`define RCA_REG_PC        8'h08
`define RCA_REG_IR        8'h0c
`define RCA_CTRL_RUN      0
`define RCA_CTRL_INSTR_RATE_CLOCK_OUT   1
`define RCA_CTRL_MODE_LO  2
`define RCA_CTRL_MODE_HI  3
`define RCA_CTRL_MASTER_CLEAR_N     4
`define RCA_CTRL_RESET    5'h13
`define RCA_MODE_EXT_RC   2'h2
`define RCA_MODE_INT_RC   2'h3

// Status bit positions and special file addresses
`define RCA_ST_C          0
`define RCA_ST_DC         1
`define RCA_ST_Z          2
`define RCA_ST_PA0        5
`define RCA_SFR_INDF      5'h00
`define RCA_SFR_PCL       5'h02
`define RCA_SFR_STATUS    5'h03
`define RCA_SFR_FSR       5'h04
`define RCA_NOP           12'h000

// Opcode top nibble
`define RCA_TOP_BCF       4'h4
`define RCA_TOP_BSF       4'h5
`define RCA_TOP_BTFSC     4'h6
`define RCA_TOP_BTFSS     4'h7
`define RCA_TOP_RETLW     4'h8
`define RCA_TOP_CALL      4'h9
`define RCA_TOP_GOTO0     4'ha
`define RCA_TOP_GOTO1     4'hb
`define RCA_TOP_MOVLW     4'hc
`define RCA_TOP_IORLW     4'hd
`define RCA_TOP_ANDLW     4'he
`define RCA_TOP_XORLW     4'hf

// Byte-oriented sub-op (bits 9:6 when bits 11:10 are zero)
`define RCA_BOP_MISC      4'h0
`define RCA_BOP_CLR       4'h1
`define RCA_BOP_SUB       4'h2
`define RCA_BOP_DEC       4'h3
`define RCA_BOP_IOR       4'h4
`define RCA_BOP_AND       4'h5
`define RCA_BOP_XOR       4'h6
`define RCA_BOP_ADD       4'h7
`define RCA_BOP_MOV       4'h8
`define RCA_BOP_COM       4'h9
`define RCA_BOP_INC       4'ha
`define RCA_BOP_DECSZ     4'hb
`define RCA_BOP_RR        4'hc
`define RCA_BOP_RL        4'hd
`define RCA_BOP_SWAP      4'he
`define RCA_BOP_INCSZ     4'hf

// ALU operation codes
`define RCA_ALU_ADD       4'h0
`define RCA_ALU_SUB       4'h1
`define RCA_ALU_AND       4'h2
`define RCA_ALU_IOR       4'h3
`define RCA_ALU_XOR       4'h4
`define RCA_ALU_COM       4'h5
`define RCA_ALU_INC       4'h6
`define RCA_ALU_DEC       4'h7
`define RCA_ALU_RR        4'h8
`define RCA_ALU_RL        4'h9
`define RCA_ALU_SWAP      4'ha
`define RCA_ALU_PASS      4'hb
`define RCA_ALU_CLR       4'hc
`define RCA_ALU_BCLR      4'hd
`define RCA_ALU_BSET      4'he

`endif

// ==== hdl/rca_regfile.v ====
// Data register file: one write port, one read port with registered data.
// Assumes write and read addresses come from the core on the same clock.
`timescale 1ns/1ps
module rca_regfile #(
   parameter AW = 5,
   parameter DW = 8
) (
   input  wire          clk,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   input  wire          re,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   ////////////////////////////////////////////////////////////////////////
   // Storage has no reset; software must initialise general registers
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule

// ==== hdl/rca_alu.v ====
// Eight-bit arithmetic unit: combinational result, carry and digit carry.
// Assumes the core picks flags to keep; zero is derived from the result.
`timescale 1ns/1ps
`include "rca_consts.vh"
module rca_alu (
   input  wire [3:0] op,
   input  wire [7:0] a,
   input  wire [7:0] w,
   input  wire       cin,
   input  wire [2:0] bsel,
   output reg  [7:0] y,
   output reg        cout,
   output reg        dcout
);
   wire [8:0] sum  = {1'b0, a} + {1'b0, w};
   wire [4:0] nsum = {1'b0, a[3:0]} + {1'b0, w[3:0]};
   wire [7:0] mask = 8'h01 << bsel;

   ////////////////////////////////////////////////////////////////////////
   // Operation select; unused carry follows the input and digit carry is zero, so nothing latches
   always @* begin
      y     = a;
      cout  = cin;
      dcout = 1'b0;
      case (op)
         `RCA_ALU_ADD: begin
            y     = sum[7:0];
            cout  = sum[8];
            dcout = nsum[4];
         end
         `RCA_ALU_SUB: begin
            y     = a - w;
            cout  = (a >= w);
            dcout = (a[3:0] >= w[3:0]);
         end
         `RCA_ALU_AND:  y = a & w;
         `RCA_ALU_IOR:  y = a | w;
         `RCA_ALU_XOR:  y = a ^ w;
         `RCA_ALU_COM:  y = ~a;
         `RCA_ALU_INC:  y = a + 8'h01;
         `RCA_ALU_DEC:  y = a - 8'h01;
         `RCA_ALU_RR: begin
            y    = {cin, a[7:1]};
            cout = a[0];
         end
         `RCA_ALU_RL: begin
            y    = {a[6:0], cin};
            cout = a[7];
         end
         `RCA_ALU_SWAP: y = {a[3:0], a[7:4]};
         `RCA_ALU_PASS: y = a;
         `RCA_ALU_CLR:  y = 8'h00;
         `RCA_ALU_BCLR: y = a & ~mask;
         `RCA_ALU_BSET: y = a | mask;
         default:       y = a;
      endcase
   end
endmodule

// ==== hdl/rca_core.v ====
// Eight-bit core: four-phase sequencer, two-stage fetch/execute pipeline,
// accumulator, status flags, file map special registers, two-level stack.
// Assumes program memory answers an address within three clocks and that
// the register bus master runs on clk.
`timescale 1ns/1ps
`include "rca_consts.vh"
module rca_core #(
   parameter PC_W = 10,
   parameter FA_W = 5
) (
   input  wire            clk,
   input  wire            arst_n,
   input  wire            master_clear_n,
   output wire [PC_W-1:0] prog_addr,
   input  wire [11:0]     prog_data,
   input  wire [7:0]      reg_addr,
   input  wire [31:0]     reg_wdata,
   input  wire            reg_wr,
   input  wire            reg_rd,
   output reg  [31:0]     reg_rdata,
   output reg             instr_rate_clock_out,
   output reg             oscillator_output_oe_n,
   input  wire            oscillator_output_in
);
   reg  [1:0]      ph_r;
   reg  [PC_W-1:0] pc_r;
   reg  [PC_W-1:0] pa_r;
   reg  [11:0]     fetch_r;
   reg             flush_r;
   reg  [11:0]     ir_r;
   reg  [7:0]      w_r;
   reg             c_r;
   reg             dc_r;
   reg             z_r;
   reg             pa0_r;
   reg  [7:0]      fsr_r;
   reg  [PC_W-1:0] stk0_r;
   reg  [PC_W-1:0] stk1_r;
   reg  [4:0]      ctrl_r;
   reg             master_clear_n_s1_r;
   reg             master_clear_n_s2_r;
   reg             pin_s1_r;
   reg             pin_s2_r;

   // Decode results
   reg  [3:0]      alu_op;
   reg             use_lit;
   reg             dest_w;
   reg             dest_f;
   reg             aff_z;
   reg             aff_c;
   reg             aff_dc;
   reg             do_goto;
   reg             do_call;
   reg             do_ret;
   reg             skip_zero;
   reg             skip_bclr;
   reg             skip_bset;
   reg  [7:0]      fval;

   wire [7:0]      alu_y;
   wire            alu_c;
   wire            alu_dc;
   wire [7:0]      rf_rdata;
   wire            run       = ctrl_r[`RCA_CTRL_RUN];
   wire            ph4       = run && (ph_r == `RCA_PH_FOUR);
   wire            core_rst  = ctrl_r[`RCA_CTRL_MASTER_CLEAR_N] && !master_clear_n_s2_r;
   wire [FA_W-1:0] eff_addr  = (ir_r[4:0] == `RCA_SFR_INDF) ? fsr_r[FA_W-1:0] : ir_r[FA_W-1:0];
   wire [7:0]      status    = {2'h0, pa0_r, 2'h3, z_r, dc_r, c_r};
   wire [7:0]      opnd      = use_lit ? (ir_r[11] ? ir_r[7:0] : 8'h00) : fval;
   wire            yzero     = (alu_y == 8'h00);
   wire            opnd_bit  = opnd[ir_r[7:5]];
   wire            skip      = (skip_zero && yzero) || (skip_bclr && !opnd_bit) ||
                               (skip_bset && opnd_bit);
   wire            wr_pcl    = dest_f && (eff_addr == `RCA_SFR_PCL);
   wire            wr_stat   = dest_f && (eff_addr == `RCA_SFR_STATUS);
   wire            wr_fsr    = dest_f && (eff_addr == `RCA_SFR_FSR);
   wire            rf_we     = ph4 && dest_f && !wr_pcl && !wr_stat && !wr_fsr &&
                               (ir_r[4:0] != `RCA_SFR_INDF || fsr_r[4:0] != `RCA_SFR_INDF);
   wire            rc_mode   = (ctrl_r[`RCA_CTRL_MODE_HI:`RCA_CTRL_MODE_LO] == `RCA_MODE_EXT_RC) ||
                               (ctrl_r[`RCA_CTRL_MODE_HI:`RCA_CTRL_MODE_LO] == `RCA_MODE_INT_RC);

   assign prog_addr = pa_r;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; first stage feeds only the second
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         master_clear_n_s1_r <= 1'b1;
         master_clear_n_s2_r <= 1'b1;
         pin_s1_r  <= 1'b0;
         pin_s2_r  <= 1'b0;
      end else begin
         master_clear_n_s1_r <= master_clear_n;
         master_clear_n_s2_r <= master_clear_n_s1_r;
         pin_s1_r  <= oscillator_output_in;
         pin_s2_r  <= pin_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction decode; literal forms feed the ALU through use_lit
   always @* begin
      alu_op    = `RCA_ALU_PASS;
      use_lit   = 1'b0;
      dest_w    = 1'b0;
      dest_f    = 1'b0;
      aff_z     = 1'b0;
      aff_c     = 1'b0;
      aff_dc    = 1'b0;
      do_goto   = 1'b0;
      do_call   = 1'b0;
      do_ret    = 1'b0;
      skip_zero = 1'b0;
      skip_bclr = 1'b0;
      skip_bset = 1'b0;
      if (ir_r[11:10] == 2'h0) begin
         dest_w = !ir_r[5];
         dest_f = ir_r[5];
         aff_z  = 1'b1;
         case (ir_r[9:6])
            `RCA_BOP_MISC: begin
               dest_w = 1'b0;                   // Only the store form writes
               aff_z  = 1'b0;
               alu_op = `RCA_ALU_PASS;
               use_lit = 1'b1;
            end
            `RCA_BOP_CLR:   alu_op = `RCA_ALU_CLR;
            `RCA_BOP_SUB: begin
               alu_op = `RCA_ALU_SUB;
               aff_c  = 1'b1;
               aff_dc = 1'b1;
            end
            `RCA_BOP_DEC:   alu_op = `RCA_ALU_DEC;
            `RCA_BOP_IOR:   alu_op = `RCA_ALU_IOR;
            `RCA_BOP_AND:   alu_op = `RCA_ALU_AND;
            `RCA_BOP_XOR:   alu_op = `RCA_ALU_XOR;
            `RCA_BOP_ADD: begin
               alu_op = `RCA_ALU_ADD;
               aff_c  = 1'b1;
               aff_dc = 1'b1;
            end
            `RCA_BOP_MOV:   alu_op = `RCA_ALU_PASS;
            `RCA_BOP_COM:   alu_op = `RCA_ALU_COM;
            `RCA_BOP_INC:   alu_op = `RCA_ALU_INC;
            `RCA_BOP_DECSZ: begin
               alu_op    = `RCA_ALU_DEC;
               aff_z     = 1'b0;
               skip_zero = 1'b1;
            end
            `RCA_BOP_RR: begin
               alu_op = `RCA_ALU_RR;
               aff_z  = 1'b0;
               aff_c  = 1'b1;
            end
            `RCA_BOP_RL: begin
               alu_op = `RCA_ALU_RL;
               aff_z  = 1'b0;
               aff_c  = 1'b1;
            end
            `RCA_BOP_SWAP: begin
               alu_op = `RCA_ALU_SWAP;
               aff_z  = 1'b0;
            end
            `RCA_BOP_INCSZ: begin
               alu_op    = `RCA_ALU_INC;
               aff_z     = 1'b0;
               skip_zero = 1'b1;
            end
            default: alu_op = `RCA_ALU_PASS;
         endcase
         // The store form ORs the accumulator onto a zero operand
         if (ir_r[9:6] == `RCA_BOP_MISC && ir_r[5]) begin
            alu_op = `RCA_ALU_IOR;
         end
         // Clear of the accumulator has the d bit low
         if (ir_r[9:6] == `RCA_BOP_CLR) begin
            aff_z = 1'b1;
         end
      end else begin
         use_lit = ir_r[11];
         case (ir_r[11:8])
            `RCA_TOP_BCF: begin
               alu_op = `RCA_ALU_BCLR;
               dest_f = 1'b1;
            end
            `RCA_TOP_BSF: begin
               alu_op = `RCA_ALU_BSET;
               dest_f = 1'b1;
            end
            `RCA_TOP_BTFSC: skip_bclr = 1'b1;
            `RCA_TOP_BTFSS: skip_bset = 1'b1;
            `RCA_TOP_RETLW: begin
               dest_w = 1'b1;
               do_ret = 1'b1;
            end
            `RCA_TOP_CALL:  do_call = 1'b1;
            `RCA_TOP_GOTO0, `RCA_TOP_GOTO1: do_goto = 1'b1;
            `RCA_TOP_MOVLW: dest_w = 1'b1;
            `RCA_TOP_IORLW: begin
               alu_op = `RCA_ALU_IOR;
               dest_w = 1'b1;
               aff_z  = 1'b1;
            end
            `RCA_TOP_ANDLW: begin
               alu_op = `RCA_ALU_AND;
               dest_w = 1'b1;
               aff_z  = 1'b1;
            end
            `RCA_TOP_XORLW: begin
               alu_op = `RCA_ALU_XOR;
               dest_w = 1'b1;
               aff_z  = 1'b1;
            end
            default: alu_op = `RCA_ALU_PASS;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // File operand: special registers override the memory read
   always @* begin
      case (eff_addr)
         `RCA_SFR_INDF:   fval = 8'h00;         // Indirect through itself reads zero
         `RCA_SFR_PCL:    fval = pa_r[7:0];
         `RCA_SFR_STATUS: fval = status;
         `RCA_SFR_FSR:    fval = fsr_r;
         default:         fval = rf_rdata;
      endcase
   end

   rca_alu u_alu (
      .op    (alu_op),
      .a     (opnd),
      .w     (w_r),
      .cin   (c_r),
      .bsel  (ir_r[7:5]),
      .y     (alu_y),
      .cout  (alu_c),
      .dcout (alu_dc)
   );

   rca_regfile #(.AW(FA_W), .DW(8)) u_rf (
      .clk   (clk),
      .we    (rf_we),
      .waddr (eff_addr),
      .wdata (alu_y),
      .re    (run && ph_r == `RCA_PH_TWO),
      .raddr (eff_addr),
      .rdata (rf_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer, pipeline and architectural state
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_r    <= `RCA_PH_ONE;
         pc_r    <= {PC_W{1'b0}};
         pa_r    <= {PC_W{1'b0}};
         fetch_r <= `RCA_NOP;
         flush_r <= 1'b1;
         ir_r    <= `RCA_NOP;
         w_r     <= 8'h00;
         c_r     <= 1'b0;
         dc_r    <= 1'b0;
         z_r     <= 1'b0;
         pa0_r   <= 1'b0;
         fsr_r   <= 8'h00;
         stk0_r  <= {PC_W{1'b0}};
         stk1_r  <= {PC_W{1'b0}};
      end else if (core_rst) begin
         ph_r    <= `RCA_PH_ONE;
         pc_r    <= {PC_W{1'b0}};
         pa_r    <= {PC_W{1'b0}};
         fetch_r <= `RCA_NOP;
         flush_r <= 1'b1;
         ir_r    <= `RCA_NOP;
         w_r     <= 8'h00;
         c_r     <= 1'b0;
         dc_r    <= 1'b0;
         z_r     <= 1'b0;
         pa0_r   <= 1'b0;
         fsr_r   <= 8'h00;
         stk0_r  <= {PC_W{1'b0}};
         stk1_r  <= {PC_W{1'b0}};
      end else if (run) begin
         ph_r <= ph_r + 2'h1;
         // Phase one: take the prefetched word, fetch the next
         if (ph_r == `RCA_PH_ONE) begin
            ir_r    <= flush_r ? `RCA_NOP : fetch_r;
            flush_r <= 1'b0;
            pa_r    <= pc_r;
            pc_r    <= pc_r + {{(PC_W-1){1'b0}}, 1'b1};
         end
         // Phase four: latch fetched word and retire the instruction
         if (ph_r == `RCA_PH_FOUR) begin
            fetch_r <= prog_data;
            if (dest_w) begin
               w_r <= alu_y;
            end
            if (wr_stat) begin
               pa0_r <= alu_y[`RCA_ST_PA0];
               // Flag bits take the write only if the op leaves them alone
               if (!aff_z)  z_r  <= alu_y[`RCA_ST_Z];
               if (!aff_c)  c_r  <= alu_y[`RCA_ST_C];
               if (!aff_dc) dc_r <= alu_y[`RCA_ST_DC];
            end
            if (wr_fsr) begin
               fsr_r <= alu_y;
            end
            if (aff_z)  z_r  <= yzero;
            if (aff_c)  c_r  <= alu_c;
            if (aff_dc) dc_r <= alu_dc;
            // Flow changes discard the word fetched this cycle
            if (do_goto) begin
               pc_r    <= {pa0_r, ir_r[8:0]};
               flush_r <= 1'b1;
            end else if (do_call) begin
               stk1_r  <= stk0_r;
               stk0_r  <= pa_r;
               pc_r    <= {pa0_r, 1'b0, ir_r[7:0]};
               flush_r <= 1'b1;
            end else if (do_ret) begin
               pc_r    <= stk0_r;
               stk0_r  <= stk1_r;
               flush_r <= 1'b1;
            end else if (wr_pcl) begin
               pc_r    <= {pa0_r, 1'b0, alu_y};
               flush_r <= 1'b1;
            end else if (skip) begin
               flush_r <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register; kept across master clear so the pin stays usable
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= `RCA_CTRL_RESET;
      end else if (reg_wr && reg_addr == `RCA_REG_CTRL) begin
         ctrl_r <= reg_wdata[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after the strobe
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `RCA_REG_CTRL:  reg_rdata <= {27'h0, ctrl_r};
            `RCA_REG_STATE: reg_rdata <= {7'h0, pin_s2_r, fsr_r, status, w_r};
            `RCA_REG_PC:    reg_rdata <= {{(32-PC_W){1'b0}}, pa_r};
            `RCA_REG_IR:    reg_rdata <= {20'h0, ir_r};
            default:        reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Quarter-rate clock out: high in phases two and three, pin drive in RC modes only
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         instr_rate_clock_out   <= 1'b0;
         oscillator_output_oe_n <= 1'b1;
      end else begin
         instr_rate_clock_out   <= (ph_r == `RCA_PH_ONE) || (ph_r == `RCA_PH_TWO);
         oscillator_output_oe_n <= !(rc_mode && ctrl_r[`RCA_CTRL_INSTR_RATE_CLOCK_OUT]);
      end
   end
endmodule

// ==== tb/rca_prog_model.sv ====
// Program memory model holding the fixed test program.
// Assumes prog_addr is steady while the core reads a word.
`timescale 1ns/1ps
module rca_prog_model (
   input  wire [9:0]  prog_addr,
   output reg  [11:0] prog_data
);
   // Whole word follows the address; ten address bits wrap by themselves
   always @* begin
      case (prog_addr)
         10'h000, 10'h004: prog_data = 12'hc3a;
         10'h001: prog_data = 12'h026;
         10'h002: prog_data = 12'hcc7;
         10'h003: prog_data = 12'h1c6;
         10'h005, 10'h007: prog_data = 12'h086;
         10'h006: prog_data = 12'hc3b;
         10'h008: prog_data = 12'ha0c;
         10'h00c: prog_data = 12'h1e6;
         10'h00d: prog_data = 12'ha0d;
         default: prog_data = 12'hc55; // Would spoil W if a flush failed
      endcase
   end
endmodule

// ==== tb/rca_core_assertions.sv ====
// Port checker for the core: bus answers, pin drive, clock out, fetch.
// Assumes run and master-clear enable stay set while it watches.
`timescale 1ns/1ps
`include "rca_consts.vh"
module rca_core_checker (
   input wire        clk,
   input wire        arst_n,
   input wire        master_clear_n,
   input wire [9:0]  prog_addr,
   input wire [7:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata,
   input wire        instr_rate_clock_out,
   input wire        oscillator_output_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Pin drive wanted: clock out on and an RC mode
   wire ctrl_wr = reg_wr && reg_addr == `RCA_REG_CTRL;
   wire drv     = reg_wdata[1] && reg_wdata[3];
   wire unmap   = reg_addr[1:0] != 2'h0 || reg_addr > 8'h0c;
   ////////////////////////////////////////////////////////////////////////
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_rd_unmap; reg_rd && unmap |=> reg_rdata == 32'h0; endproperty
   a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read");
   property p_rd_ctrl; reg_rd && reg_addr == `RCA_REG_CTRL |=> reg_rdata[31:5] == 27'h0; endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("control upper bits");
   property p_rd_pc; reg_rd && reg_addr == `RCA_REG_PC |=> reg_rdata[31:10] == 22'h0; endproperty
   a_rd_pc: assert property (p_rd_pc) else $error("counter upper bits");
   property p_oe_on; ctrl_wr && drv |-> ##[1:3] !oscillator_output_oe_n; endproperty
   a_oe_on: assert property (p_oe_on) else $error("pin not driven");
   property p_oe_off; ctrl_wr && !drv |-> ##[1:3] oscillator_output_oe_n; endproperty
   a_oe_off: assert property (p_oe_off) else $error("pin driven");
   // A held clear parks the phases, so shape and hold checks pause then
   property p_clk_out;
      disable iff (!arst_n || !master_clear_n)
      $rose(instr_rate_clock_out) |=> instr_rate_clock_out ##1 !instr_rate_clock_out [*2] ##1 instr_rate_clock_out;
   endproperty
   a_clk_out: assert property (p_clk_out) else $error("clock out shape");
   property p_fetch_hold;
      disable iff (!arst_n || !master_clear_n)
      $changed(prog_addr) |=> $stable(prog_addr) [*3];
   endproperty
   a_fetch_hold: assert property (p_fetch_hold) else $error("fetch address moved");
   property p_master_clear_n; !master_clear_n [*8] |-> ##2 prog_addr == 10'h000; endproperty
   a_master_clear_n: assert property (p_master_clear_n) else $error("clear ignored");
   // Main scenarios reached
   c_master_clear_n: cover property (!master_clear_n [*8]);
   c_oe: cover property ($fell(oscillator_output_oe_n));
   c_rd: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind rca_core rca_core_checker u_chk (.clk(clk), .arst_n(arst_n), .master_clear_n(master_clear_n),
   .prog_addr(prog_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .instr_rate_clock_out(instr_rate_clock_out),
   .oscillator_output_oe_n(oscillator_output_oe_n));

// ==== tb/rca_core_test.sv ====
// Bench for the core: runs the model program, probes state over the bus.
// Assumes the program model holds the matching test program.
`timescale 1ns/1ps
module rca_core_test;
   reg         clk, arst_n, master_clear_n, reg_wr, reg_rd, ext_pin;
   reg  [7:0]  reg_addr;
   reg  [31:0] reg_wdata, d;
   wire [9:0]  prog_addr;
   wire [11:0] prog_data;
   wire [31:0] reg_rdata;
   wire        clk_out, oe_n;
   wire        pin = oe_n ? ext_pin : clk_out; // Core drives pin when oe_n low
   integer     mismatches, checked, n, m;
   integer     rises = 0;
   rca_core u_dut (.clk(clk), .arst_n(arst_n), .master_clear_n(master_clear_n), .prog_addr(prog_addr),
      .prog_data(prog_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .instr_rate_clock_out(clk_out), .oscillator_output_oe_n(oe_n),
      .oscillator_output_in(pin));
   rca_prog_model u_rom (.prog_addr(prog_addr), .prog_data(prog_data));
   always @(posedge clk_out) rises = rises + 1;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task give_verdict;
      begin
         if (mismatches == 0 && checked > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] v);
      begin
         @(posedge clk);
         reg_wr    <= 1'b1;
         reg_addr  <= a;
         reg_wdata <= v;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   // Read data stands only in the cycle after the strobe
   task rd(input [7:0] a);
      begin
         @(posedge clk);
         reg_rd   <= 1'b1;
         reg_addr <= a;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1 d = reg_rdata;
      end
   endtask
   // Bounded wait for a fetch address; n counts the clocks spent
   task wait_pc(input [9:0] a);
      begin
         n = 0;
         while (prog_addr !== a) begin
            @(posedge clk);
            #1 n = n + 1;
            if (n > 999) begin
               mismatches = mismatches + 1;
               give_verdict;
            end
         end
      end
   endtask
   // Four clocks after fetch of a, the word before a has written back
   task probe(input [9:0] a);
      begin
         wait_pc(a);
         repeat (4) @(posedge clk);
         rd(8'h04);
      end
   endtask
   function [31:0] st(input [7:0] s, input [7:0] w);
      st = {7'h0, ext_pin, 8'h00, s, w};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      arst_n = 1'b0;
      master_clear_n = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      ext_pin = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      mismatches = 0;
      checked = 0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      #1 check({22'h0, prog_addr}, 32'h0);
      rd(8'h00);
      check(d, 32'h13);
      rd(8'h10);
      check(d, 32'h0);
      probe(10'h004);
      check(d, st(8'h1b, 8'h01));
      probe(10'h006);
      check(d, st(8'h1f, 8'h00));
      wait_pc(10'h008);
      wait_pc(10'h00c);
      check(n, 8);
      repeat (4) @(posedge clk);
      rd(8'h04);
      check(d, st(8'h18, 8'hff));
      probe(10'h00d);
      check(d, st(8'h1b, 8'hff));
      wr(8'h04, 32'h0);
      rd(8'h04);
      check(d, st(8'h1b, 8'hff));
      // Pin is driven only in the two RC modes
      for (m = 0; m < 4; m = m + 1) begin
         wr(8'h00, 32'h13 | (m << 2));
         repeat (4) @(posedge clk);
         #1 check({31'h0, oe_n}, {31'h0, m < 2});
      end
      @(posedge clk);
      #1 n = rises;
      repeat (40) @(posedge clk);
      #1 check(rises - n, 10);
      wr(8'h00, 32'h13);
      master_clear_n <= 1'b0;
      repeat (20) @(posedge clk);
      #1 check({22'h0, prog_addr}, 32'h0);
      rd(8'h04);
      check(d, st(8'h18, 8'h00));
      rd(8'h08);
      check(d, 32'h0);
      rd(8'h0c);
      check(d, 32'h0);
      @(posedge clk);
      master_clear_n <= 1'b1;
      probe(10'h004);
      check(d, st(8'h1b, 8'h01));
      give_verdict;
   end
endmodule
